// ---- design/rom_pin_mux_pkg.sv ----
// constants, pin map and config layout for the rom buffer / gpio pin mux
package rom_pin_mux_pkg;
    // --------------------------------------------------------------------
    // pin and group map: pin = group*8 + bit, groups are GP1,GP2,GP4..GP7
    // --------------------------------------------------------------------
    localparam int NUM_GROUPS = 6;
    localparam int NUM_PINS   = 48;
    localparam logic [2:0] GRP_ONE   = 3'h0;
    localparam logic [2:0] GRP_TWO   = 3'h1;
    localparam logic [2:0] GRP_FOUR  = 3'h2;
    localparam logic [2:0] GRP_FIVE  = 3'h3;
    localparam logic [2:0] GRP_SIX   = 3'h4;
    localparam logic [2:0] GRP_SEVEN = 3'h5;
    // register indices as seen through the index/data pair
    localparam logic [3:0] IDX_GP1 = 4'h1;
    localparam logic [3:0] IDX_GP2 = 4'h2;
    localparam logic [3:0] IDX_GP4 = 4'h4;
    localparam logic [3:0] IDX_GP5 = 4'h5;
    localparam logic [3:0] IDX_GP6 = 4'h6;
    localparam logic [3:0] IDX_GP7 = 4'h7;
    // special pins
    localparam int ROM_SEL_PIN = 27;
    localparam int ROM_OE_PIN  = 28;
    localparam int RD_BASE     = 32;
    localparam int SER2_BASE   = 40;
    // pin class masks
    localparam logic [47:0] IMPL_MASK    = 48'hFFFF_FFFF_3FFF;
    localparam logic [47:0] SHARED_MASK  = 48'hFFFF_FFFF_0000;
    localparam logic [47:0] SER2_MASK    = 48'hFF00_0000_0000;
    localparam logic [47:0] IN_ALT1_MASK = 48'h0000_0000_0203;
    localparam logic [47:0] IN_ALT2_MASK = 48'h0000_0000_0206;
    localparam logic [47:0] KBC_A1_MASK  = 48'h0000_0000_2000;
    localparam logic [47:0] KBC_A2_MASK  = 48'h00FC_0000_0100;
    // --------------------------------------------------------------------
    // per-pin configuration
    // --------------------------------------------------------------------
    typedef struct packed {
        logic open_drain;
        logic alt_second;
        logic alt_sel;
        logic int_en;
        logic invert;
        logic dir_in;
    } pin_cfg_s;
    localparam pin_cfg_s CFG_RESET = 6'h01;
    localparam int       KBC_PULSE_CLKS = 3;
    localparam logic [1:0] KBC_PULSE_LOAD = 2'h3;
endpackage

// ---- design/rom_buffer_gpio_pin_mux.sv ----
// rom data transceiver, keyboard port pin drive and gpio pin multiplexing
`timescale 1ns/1ps
// Functional notes
// RULE1: select low: direction picks rom/system transfer
// RULE2: alternate rom pins keep alternate value outbound
// RULE3: output enable alternate makes rom bus read-only
// RULE4: read-only: every rom pin copied to system
// RULE5: select alternate: rom bus floats, isolated
// RULE6: keyboard port: 0 drives low, 1 pulses high
// RULE7: open drain keyboard port: 1 tristates pin
// RULE8: keyboard port ignores direction and polarity bits
// RULE9: rom pins 2-7 offer keyboard port bits
// RULE10: reset makes all gpio plain inputs
// RULE11: fourteen dedicated ports in two registers
// RULE12: first group alternates as listed
// RULE13: second group six bits, listed alternates
// RULE14: three input-type alternates, rest outputs
// RULE15: shared pins default original, switchable gpio
// RULE16: ide chip selects default original decoding
// RULE17: board uses port bit 21 gate, 20 reset
// RULE18: software keeps select high while reprogramming
// RULE19: config nibble: alt, int, invert, direction
// RULE20: original function ignores inversion
// RULE21: second serial pins high-z until enabled
// RULE22: rom drivers only original, selected, outbound
// RULE23: system bus released unless rom read
module rom_buffer_gpio_pin_mux (
    input  wire logic                       ref_clk_i,
    input  wire logic                       srst_i,
    input  wire logic                       reg_wr_i,
    input  wire logic [3:0]                 reg_index_i,
    input  wire logic [7:0]                 reg_wdata_i,
    output logic      [7:0]                 reg_rdata_o,
    input  wire logic                       cfg_wr_i,
    input  wire logic [5:0]                 cfg_pin_i,
    input  rom_pin_mux_pkg::pin_cfg_s       cfg_wdata_i,
    input  wire logic [47:0]                pin_i,
    output logic      [47:0]                pin_o,
    output logic      [47:0]                pin_oe_n_o,
    output logic      [47:0]                func_in_o,
    input  wire logic [47:0]                alt1_out_i,
    input  wire logic [47:0]                alt2_out_i,
    input  wire logic [47:0]                orig_out_i,
    input  wire logic [47:0]                orig_drive_i,
    input  wire logic                       serial2_en_i,
    input  wire logic                       rom_buffer_direction_i,
    input  wire logic [7:0]                 system_data_bus_i,
    output logic      [7:0]                 system_data_bus_o,
    output logic                            system_data_bus_oe_n_o
);
    import rom_pin_mux_pkg::*;

    // --------------------------------------------------------------------
    // input synchronisers
    // --------------------------------------------------------------------
    logic [47:0] pin_s1_q;
    logic [47:0] pin_s2_q;
    logic [7:0]  sd_s1_q;
    logic [7:0]  sd_s2_q;
    logic        dir_s1_q;
    logic        dir_s2_q;

    always_ff @(posedge ref_clk_i) begin
        pin_s1_q <= pin_i;
        pin_s2_q <= pin_s1_q;
        sd_s1_q  <= system_data_bus_i;
        sd_s2_q  <= sd_s1_q;
        dir_s1_q <= rom_buffer_direction_i;
        dir_s2_q <= dir_s1_q;
    end

    // --------------------------------------------------------------------
    // configuration and port data registers
    // --------------------------------------------------------------------
    pin_cfg_s    cfg_q [NUM_PINS];
    logic [47:0] data_q;
    logic [2:0]  grp;
    logic        grp_ok;

    always_comb begin
        grp_ok = 1'b1;
        case (reg_index_i)
            IDX_GP1: grp = GRP_ONE;
            IDX_GP2: grp = GRP_TWO;
            IDX_GP4: grp = GRP_FOUR;
            IDX_GP5: grp = GRP_FIVE;
            IDX_GP6: grp = GRP_SIX;
            IDX_GP7: grp = GRP_SEVEN;
            default: begin
                grp    = GRP_ONE;
                grp_ok = 1'b0;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            for (int p = 0; p < NUM_PINS; p++) begin
                cfg_q[p] <= CFG_RESET; // [RULE10] [RULE15]
            end
        end else if (cfg_wr_i && cfg_pin_i < 6'(NUM_PINS)) begin
            cfg_q[cfg_pin_i] <= cfg_wdata_i; // [RULE19]
        end
    end

    // gp2 bits 6 and 7 do not exist: writes dropped, reads zero
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            data_q <= '0;
        end else if (reg_wr_i && grp_ok) begin
            data_q[grp*8 +: 8] <= reg_wdata_i & IMPL_MASK[grp*8 +: 8]; // [RULE11] [RULE13]
        end
    end

    // --------------------------------------------------------------------
    // rom transceiver control
    // --------------------------------------------------------------------
    logic sel_int_n;
    logic oe_alt;
    logic rd_to_sd;
    logic sd_to_rd;

    // select reads the pin only in its original role; software must hold it
    // high while rom pins are being moved to other functions
    assign sel_int_n = cfg_q[ROM_SEL_PIN].alt_sel ? 1'b1 : pin_s2_q[ROM_SEL_PIN]; // [RULE5] [RULE18]
    assign oe_alt    = cfg_q[ROM_OE_PIN].alt_sel; // [RULE3]
    assign rd_to_sd  = !sel_int_n && (!dir_s2_q || oe_alt); // [RULE1] [RULE3] [RULE4]
    assign sd_to_rd  = !sel_int_n && dir_s2_q && !oe_alt; // [RULE1] [RULE22]

    // --------------------------------------------------------------------
    // keyboard port drive pulse, one counter per pin
    // --------------------------------------------------------------------
    logic [47:0] kbc_val;
    logic [47:0] kbc_mode;
    logic [47:0] kbc_prev_q;
    logic [1:0]  kbc_cnt_q [NUM_PINS];
    logic [47:0] kbc_pulse;

    for (genvar p = 0; p < NUM_PINS; p++) begin : g_kbc
        assign kbc_mode[p]  = (KBC_A2_MASK[p] && cfg_q[p].alt_sel && cfg_q[p].alt_second) ||
                              (KBC_A1_MASK[p] && cfg_q[p].alt_sel && !cfg_q[p].alt_second); // [RULE9] [RULE13]
        assign kbc_val[p]   = cfg_q[p].alt_second ? alt2_out_i[p] : alt1_out_i[p];
        assign kbc_pulse[p] = kbc_val[p] && (!kbc_prev_q[p] || kbc_cnt_q[p] != 2'h0);
        always_ff @(posedge ref_clk_i) begin
            if (srst_i) begin
                kbc_prev_q[p] <= 1'b0;
                kbc_cnt_q[p]  <= 2'h0;
            end else begin
                kbc_prev_q[p] <= kbc_val[p] && kbc_mode[p];
                if (kbc_mode[p] && kbc_val[p] && !kbc_prev_q[p]) begin
                    kbc_cnt_q[p] <= KBC_PULSE_LOAD; // [RULE6]
                end else if (kbc_cnt_q[p] != 2'h0) begin
                    kbc_cnt_q[p] <= kbc_cnt_q[p] - 2'h1;
                end
            end
        end
    end

    // --------------------------------------------------------------------
    // per-pin function select
    // --------------------------------------------------------------------
    logic [47:0] pin_d;
    logic [47:0] oe_n_d;
    logic [7:0]  rdata_d;

    always_comb begin
        logic shared;
        logic orig;
        logic gpio;
        logic alt1;
        logic alt_in;
        logic av;
        // defaults give the per-pin temporaries a value once, before the pin loop assigns them for every pin
        shared = 1'b0;
        orig   = 1'b0;
        gpio   = 1'b0;
        alt1   = 1'b0;
        alt_in = 1'b1;
        av     = 1'b0;
        for (int p = 0; p < NUM_PINS; p++) begin
            shared = SHARED_MASK[p];
            orig   = shared && !cfg_q[p].alt_sel; // [RULE15] [RULE16]
            gpio   = shared ? (cfg_q[p].alt_sel && !cfg_q[p].alt_second) : !cfg_q[p].alt_sel;
            alt1   = !shared && cfg_q[p].alt_sel && !cfg_q[p].alt_second;
            alt_in = alt1 ? IN_ALT1_MASK[p] : IN_ALT2_MASK[p]; // [RULE14]
            av     = alt1 ? alt1_out_i[p] : alt2_out_i[p]; // [RULE12]
            pin_d[p]  = 1'b0;
            oe_n_d[p] = 1'b1;
            if (!IMPL_MASK[p]) begin
                oe_n_d[p] = 1'b1;
            end else if (orig) begin
                // original role never inverts
                if (p >= RD_BASE && p < RD_BASE + 8) begin
                    pin_d[p]  = sd_s2_q[p - RD_BASE];
                    oe_n_d[p] = !sd_to_rd; // [RULE22] [RULE20]
                end else if (p == ROM_OE_PIN) begin
                    pin_d[p]  = !rd_to_sd;
                    oe_n_d[p] = 1'b0;
                end else if (p == ROM_SEL_PIN) begin
                    oe_n_d[p] = 1'b1;
                end else if (SER2_MASK[p]) begin
                    pin_d[p]  = orig_out_i[p];
                    oe_n_d[p] = !(orig_drive_i[p] && serial2_en_i); // [RULE21]
                end else begin
                    pin_d[p]  = orig_out_i[p];
                    oe_n_d[p] = !orig_drive_i[p];
                end
            end else if (gpio) begin
                pin_d[p]  = data_q[p] ^ cfg_q[p].invert;
                oe_n_d[p] = cfg_q[p].dir_in; // [RULE10] [RULE19]
            end else if (kbc_mode[p]) begin
                // direction and polarity bits are not looked at here
                pin_d[p]  = kbc_val[p]; // [RULE8]
                if (!kbc_val[p]) begin
                    oe_n_d[p] = 1'b0; // [RULE6] [RULE7]
                end else begin
                    oe_n_d[p] = cfg_q[p].open_drain || !kbc_pulse[p]; // [RULE6] [RULE7]
                end
            end else begin
                pin_d[p]  = av;
                oe_n_d[p] = alt_in; // [RULE2] [RULE14]
            end
        end
        rdata_d = '0;
        if (grp_ok) begin
            for (int b = 0; b < 8; b++) begin
                if (cfg_q[grp*8 + b].dir_in) begin
                    rdata_d[b] = pin_s2_q[grp*8 + b] ^ cfg_q[grp*8 + b].invert;
                end else begin
                    rdata_d[b] = data_q[grp*8 + b];
                end
            end
            rdata_d = rdata_d & IMPL_MASK[grp*8 +: 8];
        end
    end

    // --------------------------------------------------------------------
    // registered outputs
    // --------------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            pin_o      <= '0;
            pin_oe_n_o <= '1;
            func_in_o  <= '0;
        end else begin
            pin_o      <= pin_d;
            pin_oe_n_o <= oe_n_d;
            func_in_o  <= pin_s2_q;
        end
    end

    // the copy takes every rom pin, alternate ones included
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            system_data_bus_o      <= '0;
            system_data_bus_oe_n_o <= 1'b1;
            reg_rdata_o            <= '0;
        end else begin
            system_data_bus_o      <= pin_s2_q[RD_BASE +: 8]; // [RULE4]
            system_data_bus_oe_n_o <= !rd_to_sd; // [RULE23]
            reg_rdata_o            <= rdata_d;
        end
    end

    // --------------------------------------------------------------------
    // checks
    // --------------------------------------------------------------------
    a_sd_release: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [RULE23]
        !rd_to_sd |=> system_data_bus_oe_n_o) else $error("system bus driven outside rom read");
    a_rd_copy: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [RULE4]
        rd_to_sd |=> !system_data_bus_oe_n_o && system_data_bus_o == $past(pin_s2_q[39:32]))
        else $error("rom pins not copied to system bus");
    a_sd_to_rd: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [RULE1]
        sd_to_rd && !cfg_q[RD_BASE].alt_sel |=> !pin_oe_n_o[RD_BASE] && pin_o[RD_BASE] == $past(sd_s2_q[0]))
        else $error("system data not driven to rom pin");
    a_alt_keep: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [RULE2]
        sd_to_rd && cfg_q[RD_BASE].alt_sel && cfg_q[RD_BASE].alt_second |=> pin_o[RD_BASE] == $past(alt2_out_i[RD_BASE]))
        else $error("alternate rom pin took system data");
    a_oe_readonly: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [RULE3]
        oe_alt && !sel_int_n && !cfg_q[RD_BASE + 1].alt_sel |=> !system_data_bus_oe_n_o && pin_oe_n_o[RD_BASE + 1])
        else $error("read-only rom bus misbehaves");
    a_sel_float: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [RULE5]
        cfg_q[ROM_SEL_PIN].alt_sel && !cfg_q[RD_BASE + 1].alt_sel |=> system_data_bus_oe_n_o && pin_oe_n_o[RD_BASE + 1])
        else $error("rom bus not isolated");
    a_kbc_low: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [RULE6]
        kbc_mode[34] && !alt2_out_i[34] |=> !pin_oe_n_o[34] && !pin_o[34]) else $error("port zero not driven low");
    a_kbc_release: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [RULE6]
        (kbc_mode[34] && alt2_out_i[34])[*5] |=> pin_oe_n_o[34]) else $error("port high drive not released");
    a_kbc_odrain: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [RULE7]
        kbc_mode[34] && cfg_q[34].open_drain && alt2_out_i[34] |=> pin_oe_n_o[34])
        else $error("open drain port drove high");
    a_reset_input: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [RULE10]
        $past(srst_i) |-> pin_oe_n_o[15:0] == 16'hFFFF) else $error("gpio not input after reset");
    a_ser2_hiz: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [RULE21]
        !serial2_en_i && !cfg_q[SER2_BASE].alt_sel |=> pin_oe_n_o[SER2_BASE]) else $error("serial pin driven early");
    a_orig_noinvert: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [RULE20]
        !cfg_q[19].alt_sel && orig_drive_i[19] |=> !pin_oe_n_o[19] && pin_o[19] == $past(orig_out_i[19]))
        else $error("original pin output inverted");
    a_kbc_dir_ignored: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [RULE8]
        kbc_mode[34] && cfg_q[34].dir_in && !alt2_out_i[34] |=> !pin_oe_n_o[34])
        else $error("port pin obeyed direction bit");
endmodule

// ---- dv/rom_pin_partner.sv ----
// board-side model of the device pads: external drivers and released lines
`timescale 1ns/1ps
module rom_pin_partner (
    input  wire logic        ref_clk_i,
    input  wire logic [47:0] pin_o_i,
    input  wire logic [47:0] pin_oe_n_i,
    input  wire logic [47:0] ext_en_i,
    input  wire logic [47:0] ext_val_i,
    output logic      [47:0] pad_o
);
    // a released pad with no external driver toggles every cycle so it never passes for a held value
    logic [47:0] flt_q = 48'h0;
    always_ff @(posedge ref_clk_i) begin
        flt_q <= ~flt_q;
    end
    always_comb begin
        pad_o = (~pin_oe_n_i & pin_o_i) | (pin_oe_n_i & ext_en_i & ext_val_i) | (pin_oe_n_i & ~ext_en_i & flt_q);
    end
endmodule

// ---- dv/rom_buffer_gpio_pin_mux_tb.sv ----
// self-checking bench for the rom buffer, keyboard port and gpio pin mux
`timescale 1ns/1ps
module rom_buffer_gpio_pin_mux_tb;
    import rom_pin_mux_pkg::*;
    logic        ref_clk = 1'b0;
    logic        srst, reg_wr, cfg_wr, serial2_en, rom_dir, sd_oe_n;
    logic [3:0]  reg_index;
    logic [7:0]  reg_wdata, sd_i, reg_rdata, sd_o, rd;
    logic [5:0]  cfg_pin;
    pin_cfg_s    cfg_wdata;
    logic [47:0] pad, pin_o, pin_oe_n, alt1, alt2, orig_out, orig_drive, ext_en, ext_val, func_in;
    int          mismatches = 0;
    int          checks_done = 0;
    int          cycles = 0;
    always #25 ref_clk = ~ref_clk;
    rom_buffer_gpio_pin_mux u_dut (
        .ref_clk_i(ref_clk), .srst_i(srst), .reg_wr_i(reg_wr), .reg_index_i(reg_index),
        .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata), .cfg_wr_i(cfg_wr), .cfg_pin_i(cfg_pin),
        .cfg_wdata_i(cfg_wdata), .pin_i(pad), .pin_o(pin_o), .pin_oe_n_o(pin_oe_n), .func_in_o(func_in),
        .alt1_out_i(alt1), .alt2_out_i(alt2), .orig_out_i(orig_out), .orig_drive_i(orig_drive),
        .serial2_en_i(serial2_en), .rom_buffer_direction_i(rom_dir), .system_data_bus_i(sd_i),
        .system_data_bus_o(sd_o), .system_data_bus_oe_n_o(sd_oe_n)
    );
    rom_pin_partner u_board (
        .ref_clk_i(ref_clk), .pin_o_i(pin_o), .pin_oe_n_i(pin_oe_n),
        .ext_en_i(ext_en), .ext_val_i(ext_val), .pad_o(pad)
    );
    // ------------------------------------------------------------------
    // access tasks
    // ------------------------------------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cfg(input int pin, input logic [5:0] val);
        cfg_pin = 6'(pin);
        cfg_wdata = val;
        cfg_wr = 1'b1;
        cyc(1);
        cfg_wr = 1'b0;
        cyc(2);
    endtask
    task automatic wr_reg(input logic [3:0] idx, input logic [7:0] val);
        reg_index = idx;
        reg_wdata = val;
        reg_wr = 1'b1;
        cyc(1);
        reg_wr = 1'b0;
        cyc(2);
    endtask
    task automatic rd_reg(input logic [3:0] idx, output logic [7:0] val);
        reg_index = idx;
        cyc(2);
        val = reg_rdata;
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // a hung run would otherwise never reach the verdict
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 4000) begin
            mismatches++;
            finish_test();
        end
    end
    // ------------------------------------------------------------------
    // tests
    // ------------------------------------------------------------------
    initial begin
        {srst, reg_wr, cfg_wr, serial2_en, rom_dir} = 5'h10;
        {reg_index, reg_wdata, sd_i, cfg_pin, cfg_wdata} = 32'h0;
        {alt1, alt2, orig_out, orig_drive, ext_en, ext_val} = '0;
        ext_en[27] = 1'b1;
        ext_val[27] = 1'b1; // select held high through the gpio and shared pin setup, until the rom tests begin
        cyc(7);
        chk("pad drive in reset", {48{1'b1}}, pin_oe_n);
        srst = 1'b0;
        cyc(3);
        chk("gpio drive after reset", 48'hFFFF, 48'(pin_oe_n[15:0]));
        chk("system bus idle", 48'h1, 48'(sd_oe_n));
        $display("test reset done");
        for (int i = 0; i < 8; i++) cfg(i, 6'h00);
        wr_reg(IDX_GP1, 8'hAA);
        chk("gp1 pins", 48'hAA, 48'(pin_o[7:0]));
        chk("gp1 drive", 48'h0, 48'(pin_oe_n[7:0]));
        rd_reg(IDX_GP1, rd);
        chk("gp1 read", 48'hAA, 48'(rd));
        cfg(1, 6'h02);
        cfg(0, 6'h08);
        cfg(3, 6'h08);
        chk("gp1 drive alt", 48'h01, 48'(pin_oe_n[7:0]));
        chk("gp1 pins alt", 48'h50, 48'(pin_o[7:1]));
        ext_en[9] = 1'b1;
        ext_val[9] = 1'b1;
        cfg(9, 6'h03);
        wr_reg(IDX_GP2, 8'hFF);
        rd_reg(IDX_GP2, rd);
        chk("gp2 read", 48'h0, 48'(rd & 8'hC2));
        chk("func in", 48'h1, 48'(func_in[9]));
        wr_reg(4'h3, 8'h5A);
        rd_reg(4'h3, rd);
        chk("unmapped read", 48'h0, 48'(rd));
        $display("test gpio done");
        orig_out[19] = 1'b1;
        orig_drive[19] = 1'b1;
        cfg(19, 6'h02);
        chk("ide select original", 48'h1, 48'({pin_oe_n[19], pin_o[19]}));
        cfg(19, 6'h08);
        wr_reg(IDX_GP4, 8'h00);
        chk("ide select gpio", 48'h0, 48'({pin_oe_n[19], pin_o[19]}));
        orig_drive[40] = 1'b1;
        cyc(3);
        chk("serial2 off", 48'h1, 48'(pin_oe_n[40]));
        serial2_en = 1'b1;
        cyc(3);
        chk("serial2 on", 48'h0, 48'(pin_oe_n[40]));
        $display("test shared done");
        ext_en[39:32] = 8'hFF;
        ext_val[39:32] = 8'h5C;
        ext_val[27] = 1'b0;
        cyc(4);
        chk("rom to system", 48'h05C, 48'({sd_oe_n, sd_o}));
        ext_en[39:32] = 8'h00;
        sd_i = 8'hA3;
        rom_dir = 1'b1;
        cyc(4);
        chk("system to rom", 48'h100A3, 48'({sd_oe_n, pin_oe_n[39:32], pin_o[39:32]}));
        ext_val[27] = 1'b1;
        cyc(4);
        chk("isolated", 48'h1FF, 48'({sd_oe_n, pin_oe_n[39:32]}));
        cfg(32, 6'h18);
        ext_val[27] = 1'b0;
        cyc(4);
        chk("alt pin outbound", 48'hA2, 48'({pin_oe_n[39:32], pin_o[39:32]}));
        ext_en[39:33] = 7'h7F;
        ext_val[39:32] = 8'h5D;
        rom_dir = 1'b0;
        cyc(6);
        chk("alt pin inbound", 48'h05C, 48'({sd_oe_n, sd_o}));
        cfg(28, 6'h09);
        rom_dir = 1'b1;
        cyc(4);
        chk("read only", 48'h1FC5C, 48'({pin_oe_n[39:33], 1'b0, sd_oe_n, sd_o}));
        cfg(27, 6'h09);
        cyc(4);
        chk("select alt", 48'h1, 48'(sd_oe_n));
        $display("test rom done");
        ext_en[39:32] = 8'h00;
        cfg(34, 6'h1B);
        cyc(1);
        chk("kbc low", 48'h0, 48'({pin_oe_n[34], pin_o[34]}));
        alt2[34] = 1'b1;
        cyc(2);
        chk("kbc pulse", 48'h1, 48'({pin_oe_n[34], pin_o[34]}));
        cyc(5);
        chk("kbc release", 48'h1, 48'(pin_oe_n[34]));
        cfg(34, 6'h3B);
        cyc(2);
        chk("open drain high", 48'h1, 48'(pin_oe_n[34]));
        alt2[34] = 1'b0;
        cyc(2);
        chk("open drain low", 48'h0, 48'({pin_oe_n[34], pin_o[34]}));
        cfg(13, 6'h08);
        chk("gate port low", 48'h0, 48'({pin_oe_n[13], pin_o[13]}));
        $display("test kbc done");
        finish_test();
    end
endmodule
